// ===== logic/pscl_cfg_mem.sv
// Configuration byte store, one write port and one registered read port
`timescale 1ns/1ps
module pscl_cfg_mem
(
    input wire logic core_clk,
    input wire logic we,
    input wire logic [pscl_pkg::ADDR_W-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [pscl_pkg::ADDR_W-1:0] raddr,
    output logic [7:0] rdata
);
    import pscl_pkg::*;

    // Storage has no reset; the loader refills it after every reset
    logic [7:0] mem [0:CFG_BYTES-1];

    // ****************************************
    // Write and registered read
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (we && (waddr <= CFG_LAST))
        begin
            mem[waddr] <= wdata;
        end
        if (raddr <= CFG_LAST)
        begin
            rdata <= mem[raddr];
        end
        else
        begin
            rdata <= 8'h00;
        end
    end

endmodule : pscl_cfg_mem

// ===== logic/pscl_loader.sv
// Power-up strap sampling and configuration space loader, top level
`timescale 1ns/1ps
module pscl_loader
#(
    parameter int SAMPLE_CYCLES = pscl_pkg::SAMPLE_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] mclk_strap,
    input wire logic output_force_strap,
    input wire logic [1:0] aux_strap,
    input wire logic [1:0] slot_strap,
    input wire logic otp_image_present,
    output logic [pscl_pkg::OTP_ADDR_W-1:0] otp_addr,
    input wire logic [7:0] otp_rdata,
    input wire logic [pscl_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic cfg_ready,
    output logic [1:0] mclk_sel,
    output logic mclk_sel_reserved,
    output logic [1:0] cfg_slot,
    output logic [1:0] cfg_aux_strap,
    output logic [7:0] diff_out_en
);
    import pscl_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed
    {
        pscl_state_t st; // Loader sequence
        logic [WIN_W-1:0] win_cnt; // Cycles since reset release
        logic [1:0] mclk; // Captured clock select
        logic [1:0] slot; // Captured slot index
        logic [1:0] aux; // Captured spare straps
        logic force_on; // Captured force strap
        logic use_otp; // Load from stored image
        logic [ADDR_W-1:0] idx; // Byte being loaded
        logic [OTP_ADDR_W-1:0] otp_addr; // Stored image address
        logic [7:0] out_en; // Shadow of output enable byte
        logic [1:0] rd_sel; // Source of pending read data
        logic [7:0] rd_stat; // Status snapshot for reads
    } pscl_regs_t;

    pscl_regs_t s; // Current state
    pscl_regs_t next_s; // Next state
    logic mem_we; // Store write enable
    logic [ADDR_W-1:0] mem_waddr; // Store write address
    logic [7:0] mem_wdata; // Store write data
    logic [7:0] mem_rdata; // Store read data
    logic host_wr; // Host write accepted
    logic [7:0] status_word; // Live status

    // ****************************************
    // Helpers
    // ****************************************
    // Built-in default for one byte; everything not listed is zero
    function automatic logic [7:0] default_byte(input logic [ADDR_W-1:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            TRIM_ADDR: v = TRIM_DEFAULT[31:24];
            TRIM_ADDR + 10'h001: v = TRIM_DEFAULT[23:16];
            TRIM_ADDR + 10'h002: v = TRIM_DEFAULT[15:8];
            TRIM_ADDR + 10'h003: v = TRIM_DEFAULT[7:0];
            OUT_EN_ADDR: v = OUT_EN_RESET;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : default_byte

    // Start of a slot image in the stored memory
    function automatic logic [OTP_ADDR_W-1:0] slot_base(input logic [1:0] sl);
        return OTP_ADDR_W'(sl) * OTP_ADDR_W'(CFG_BYTES);
    endfunction : slot_base

    // ****************************************
    // Write port arbitration
    // ****************************************
    // Host writes only land once loading is finished, so a load never races them
    always_comb
    begin
        host_wr = (s.st == PSCL_READY) && wr && (addr <= CFG_LAST);
        mem_we = 1'b0;
        mem_waddr = addr;
        mem_wdata = wdata;
        if (s.st == PSCL_LD_DATA)
        begin
            mem_we = 1'b1;
            mem_waddr = s.idx;
            mem_wdata = s.use_otp ? otp_rdata : default_byte(s.idx);
        end
        else if (host_wr)
        begin
            mem_we = 1'b1;
        end
    end

    // Status byte: ready, source, slot, clock select, force, reserved clock code
    assign status_word = {(s.st == PSCL_READY), s.use_otp, s.slot, s.mclk, s.force_on,
                          (s.mclk == MCLK_RSVD)};

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        next_s = s;
        // Read data source for the following cycle
        if (rd)
        begin
            next_s.rd_sel = (addr <= CFG_LAST) ? RD_MEM : ((addr == STATUS_ADDR) ? RD_STAT : RD_NONE);
            next_s.rd_stat = status_word;
        end
        else
        begin
            // Read data stands one cycle only, so an idle cycle clears the source
            next_s.rd_sel = RD_NONE;
        end
        // Any byte landing on the enable address updates the shadow
        if (mem_we && (mem_waddr == OUT_EN_ADDR))
        begin
            next_s.out_en = mem_wdata;
        end
        case (s.st)
            PSCL_WAIT:
            begin
                // Straps count as they stand in the last cycle of the window
                if (s.win_cnt == WIN_W'(SAMPLE_CYCLES - 1))
                begin
                    next_s.mclk = mclk_strap;
                    next_s.force_on = output_force_strap;
                    next_s.aux = aux_strap;
                    next_s.slot = slot_strap;
                    next_s.use_otp = otp_image_present;
                    next_s.idx = '0;
                    next_s.st = PSCL_LD_ADDR;
                end
                else
                begin
                    next_s.win_cnt = s.win_cnt + WIN_W'(1);
                end
            end
            PSCL_LD_ADDR:
            begin
                // Stored memory answers one cycle after the address
                next_s.otp_addr = slot_base(s.slot) + OTP_ADDR_W'(s.idx);
                next_s.st = PSCL_LD_DATA;
            end
            PSCL_LD_DATA:
            begin
                if (s.idx == CFG_LAST)
                begin
                    next_s.st = PSCL_READY;
                end
                else
                begin
                    next_s.idx = s.idx + ADDR_W'(1);
                    next_s.st = PSCL_LD_ADDR;
                end
            end
            PSCL_READY:
            begin
                // Straps are never looked at again until reset
                next_s.st = PSCL_READY;
            end
            default:
            begin
                next_s.st = PSCL_WAIT;
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    // Reset throws away host writes; the next load rebuilds the space
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.st <= PSCL_WAIT;
            s.out_en <= OUT_EN_RESET;
            s.rd_sel <= RD_NONE;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ****************************************
    // Configuration store
    // ****************************************
    pscl_cfg_mem u_mem
    (
        .core_clk(core_clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(addr),
        .rdata(mem_rdata)
    );

    // ****************************************
    // Outputs
    // ****************************************
    assign cfg_ready = (s.st == PSCL_READY);
    assign mclk_sel = s.mclk;
    assign mclk_sel_reserved = (s.mclk == MCLK_RSVD);
    assign cfg_slot = s.slot;
    assign cfg_aux_strap = s.aux;
    assign otp_addr = s.otp_addr;
    // Outputs stay dark until loading ends; the strap forces the first one on
    assign diff_out_en = cfg_ready ? (s.out_en | {7'h00, s.force_on}) : 8'h00;
    // Read data selected from registered sources only
    assign rdata = (s.rd_sel == RD_MEM) ? mem_rdata : ((s.rd_sel == RD_STAT) ? s.rd_stat : 8'h00);

    // ****************************************
    // Checks
    // ****************************************
    a_window_len: assert property (@(posedge core_clk) disable iff (rst)
        (s.st == PSCL_WAIT) ##1 (s.st == PSCL_LD_ADDR) |-> $past(s.win_cnt) == WIN_W'(SAMPLE_CYCLES - 1))
        else $error("strap window length wrong");

    a_mclk_capture: assert property (@(posedge core_clk) disable iff (rst)
        (s.st == PSCL_WAIT) && (s.win_cnt == WIN_W'(SAMPLE_CYCLES - 1)) |=> mclk_sel == $past(mclk_strap))
        else $error("clock select not taken from straps");

    a_outs_off: assert property (@(posedge core_clk) disable iff (rst)
        !cfg_ready |-> diff_out_en == 8'h00)
        else $error("output enabled before load done");

    a_force_on: assert property (@(posedge core_clk) disable iff (rst)
        cfg_ready && s.force_on |-> diff_out_en[0])
        else $error("forced output not enabled");

    a_slot_addr: assert property (@(posedge core_clk) disable iff (rst)
        (s.st == PSCL_LD_ADDR) |=> otp_addr == slot_base(s.slot) + OTP_ADDR_W'($past(s.idx)))
        else $error("stored image address wrong");

    a_default_fill: assert property (@(posedge core_clk) disable iff (rst)
        (s.st == PSCL_LD_DATA) && !s.use_otp |-> mem_we && mem_wdata == default_byte(s.idx))
        else $error("default byte not written");

    a_load_order: assert property (@(posedge core_clk) disable iff (rst)
        (s.st == PSCL_LD_DATA) && (s.idx != CFG_LAST) |=> (s.st == PSCL_LD_ADDR) ##1 (s.st == PSCL_LD_DATA))
        else $error("load sequence broken");

    a_host_blocked: assert property (@(posedge core_clk) disable iff (rst)
        !cfg_ready && mem_we |-> (s.st == PSCL_LD_DATA) && (mem_waddr == s.idx))
        else $error("host write during load");

    a_strap_frozen: assert property (@(posedge core_clk) disable iff (rst)
        cfg_ready |=> $stable(s.mclk) && $stable(s.slot) && $stable(s.force_on) && cfg_ready)
        else $error("straps changed after capture");

    a_status_read: assert property (@(posedge core_clk) disable iff (rst)
        rd && (addr == STATUS_ADDR) |=> rdata == $past(status_word))
        else $error("status read data wrong");

    a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
        !$past(rd) |-> rdata == 8'h00)
        else $error("read data shown without a read");

endmodule : pscl_loader

// ===== logic/pscl_pkg.sv
// Constants, state encoding and field layout for the power-up strap config loader
package pscl_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ = 125; // Core clock rate
    localparam int SAMPLE_TIME_US = 125000; // Strap hold window, 125 ms
    localparam int SAMPLE_CYCLES = SAMPLE_TIME_US * CLK_MHZ; // Window in core cycles
    localparam int WIN_W = 24; // Window counter width

    // ****************************************
    // Configuration space layout
    // ****************************************
    localparam int CFG_BYTES = 768; // Size of the configuration space
    localparam int ADDR_W = 10; // Register port address width
    localparam int OTP_ADDR_W = 12; // Four slots of 768 bytes
    localparam logic [ADDR_W-1:0] CFG_LAST = 10'h2FF; // Last configuration byte
    localparam logic [ADDR_W-1:0] OUT_EN_ADDR = 10'h020; // Output enable byte
    localparam logic [ADDR_W-1:0] TRIM_ADDR = 10'h010; // Trim word, MSB first, 4 bytes
    localparam logic [31:0] TRIM_DEFAULT = 32'h046AAAAB; // Centre frequency trim default
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 10'h300; // Read-only loader status
    localparam logic [7:0] OUT_EN_RESET = 8'h00; // All outputs off

    // ****************************************
    // Master clock strap codes
    // ****************************************
    localparam logic [1:0] MCLK_24M576 = 2'h0; // 24.576 MHz
    localparam logic [1:0] MCLK_49M152 = 2'h1; // 49.152 MHz
    localparam logic [1:0] MCLK_20M = 2'h2; // 20 MHz
    localparam logic [1:0] MCLK_RSVD = 2'h3; // Reserved

    // Read data source selection
    localparam logic [1:0] RD_MEM = 2'h0;
    localparam logic [1:0] RD_STAT = 2'h1;
    localparam logic [1:0] RD_NONE = 2'h2;

    // Loader sequence
    typedef enum logic [2:0]
    {
        PSCL_WAIT = 3'b000, // Strap hold window
        PSCL_LD_ADDR = 3'b001, // Present source address
        PSCL_LD_DATA = 3'b010, // Write one byte
        PSCL_READY = 3'b011 // Running, host may write
    } pscl_state_t;

endpackage : pscl_pkg

// ===== verif/pscl_loader_bench.sv
// Self-checking bench for the strap sampling configuration loader
`timescale 1ns/1ps
module pscl_loader_bench;
    import pscl_pkg::*;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic core_clk, rst, force_s, use_otp, wr, rd;
    logic [1:0] mclk, aux, slot, mclk_sel, cfg_slot, cfg_aux_strap;
    logic [OTP_ADDR_W-1:0] otp_addr;
    logic [7:0] otp_rdata, wdata, rdata, diff_out_en, d;
    logic [ADDR_W-1:0] addr;
    logic cfg_ready, mclk_sel_reserved;
    int failures, checks_done, cycles;
    logic [ADDR_W-1:0] idx [8] = '{10'h000, 10'h010, 10'h011, 10'h012, 10'h013, 10'h020, 10'h155, 10'h2FF};

    // Short window keeps each boot near 1600 cycles
    pscl_loader #(.SAMPLE_CYCLES(8)) i_dut (.core_clk(core_clk), .rst(rst), .mclk_strap(mclk),
        .output_force_strap(force_s), .aux_strap(aux), .slot_strap(slot), .otp_image_present(use_otp),
        .otp_addr(otp_addr), .otp_rdata(otp_rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cfg_ready(cfg_ready), .mclk_sel(mclk_sel), .mclk_sel_reserved(mclk_sel_reserved),
        .cfg_slot(cfg_slot), .cfg_aux_strap(cfg_aux_strap), .diff_out_en(diff_out_en));
    pscl_otp_model i_otp (.core_clk(core_clk), .otp_addr(otp_addr), .otp_rdata(otp_rdata));

    // 125 MHz clock
    always #4 core_clk = ~core_clk;

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("failures %0d checks_done %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    // Watchdog, five boots need about 8000 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            stop_test();
        end
    end

    // ****************************************
    // Register port tasks
    // ****************************************
    task automatic wr_byte(input logic [ADDR_W-1:0] a, input logic [7:0] v);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wr_byte

    // Data stands only in the cycle after the strobe
    task automatic rd_byte(input logic [ADDR_W-1:0] a, output logic [7:0] v);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_byte

    // Expected content of a byte: image of the chosen slot or built-in default
    function automatic logic [7:0] exp_byte(input logic [2:0] i, input logic [ADDR_W-1:0] a);
        logic [11:0] oa;
        logic [1:0] s;
        s = i[1:0] - 2'h1;
        oa = {10'h000, s} * 12'h300 + {2'h0, a};
        if (i != 3'h0)
            return oa[7:0] + {4'h0, oa[11:8]};
        if (a >= TRIM_ADDR && a <= TRIM_ADDR + 10'h003)
            return TRIM_DEFAULT[31 - 8 * (a - TRIM_ADDR) -: 8];
        return 8'h00;
    endfunction : exp_byte

    // ****************************************
    // One power-up with strap set i, then host traffic
    // ****************************************
    task automatic boot(input logic [2:0] i);
        int n;
        int k;
        @(posedge core_clk);
        mclk <= i[1:0];
        force_s <= i[0];
        aux <= ~i[1:0];
        slot <= i[1:0] - 2'h1;
        use_otp <= (i != 3'h0);
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        n = 0;
        // Straps held through the window and load
        while (cfg_ready !== 1'b1 && n < 4000)
        begin
            @(negedge core_clk);
            n++;
            if (cfg_ready !== 1'b1)
                chk(diff_out_en, 8'h00);
        end
        if (n >= 4000)
            failures++;
        // Board frees the pins, which now show other levels
        @(posedge core_clk);
        mclk <= ~i[1:0];
        force_s <= ~i[0];
        aux <= i[1:0];
        slot <= ~(i[1:0] - 2'h1);
        use_otp <= (i == 3'h0);
        repeat (3) @(posedge core_clk);
        #1;
        chk({6'h00, mclk_sel}, {6'h00, i[1:0]});
        chk({7'h00, mclk_sel_reserved}, {7'h00, i[1:0] == 2'h3});
        chk({4'h0, cfg_aux_strap, cfg_slot}, {4'h0, ~i[1:0], i[1:0] - 2'h1});
        chk(diff_out_en, exp_byte(i, OUT_EN_ADDR) | {7'h00, i[0]});
        for (k = 0; k < 8; k++)
        begin
            rd_byte(idx[k], d);
            chk(d, exp_byte(i, idx[k]));
        end
        // Refused write to status, then status snapshot
        wr_byte(STATUS_ADDR, 8'h00);
        rd_byte(STATUS_ADDR, d);
        chk(d, {1'b1, i != 3'h0, i[1:0] - 2'h1, i[1:0], i[0], i[1:0] == 2'h3});
        rd_byte(10'h3FF, d);
        chk(d, 8'h00);
        // Host writes, lost again at the next boot
        wr_byte(OUT_EN_ADDR, 8'h84);
        wr_byte(CFG_LAST, 8'h5A);
        rd_byte(CFG_LAST, d);
        chk(d, 8'h5A);
        // Read data must be gone one cycle later
        @(posedge core_clk);
        #1 chk(rdata, 8'h00);
        rd_byte(OUT_EN_ADDR, d);
        chk(d, 8'h84);
        chk(diff_out_en, {7'h42, i[0]});
    endtask : boot

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        core_clk = 1'b0;
        rst = 1'b1;
        mclk = 2'h0;
        force_s = 1'b0;
        aux = 2'h0;
        slot = 2'h0;
        use_otp = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = 8'h00;
        failures = 0;
        checks_done = 0;
        cycles = 0;
        // Defaults first, then every slot and every clock code
        for (int i = 0; i < 5; i++)
        begin
            boot(3'(i));
        end
        stop_test();
    end
endmodule : pscl_loader_bench

// ===== verif/pscl_otp_model.sv
// Stored one-time-programmable image model with a combinational read port
`timescale 1ns/1ps
// ****************************************
// Stored image model
// ****************************************
module pscl_otp_model
(
    input wire logic core_clk,
    input wire logic [pscl_pkg::OTP_ADDR_W-1:0] otp_addr,
    output logic [7:0] otp_rdata
);
    import pscl_pkg::*;
    // Data follows the registered address, so it stands in the cycle the loader writes it
    // Pattern mixes slot bits in, so a wrong slot gives wrong bytes
    always_comb
    begin
        otp_rdata = otp_addr[7:0] + {4'h0, otp_addr[11:8]};
    end
endmodule : pscl_otp_model
